//--- core/gpdsc_top.sv
`timescale 1ns/1ps
`default_nettype none
module gpdsc_top (
    input wire logic CLOCK_IN,
    input wire logic RST_N_IN,
    input wire gpdsc_pkg::gpdsc_mode_t MODE_IN,
    input wire logic LINK_UP_IN,
    input wire logic CARRIER_SENSE_IN,
    input wire logic CLK125_IN,
    input wire logic OPTICAL_SIGNAL_LOSS_IN,
    input wire logic SERIAL_TX_CLOCK_ENABLE_IN,
    input wire logic SERIAL_TX_CLOCK_ENABLE_WRITE_IN,
    input wire gpdsc_pkg::gpdsc_pin_cfg_t [1:0] OUT_CFG_IN,
    input wire gpdsc_pkg::gpdsc_pin_cfg_t [6:0] IO_CFG_IN,
    input wire logic GENERAL_OUT_A_IN,
    input wire logic [6:0] GENERAL_IO_IN,
    output gpdsc_pkg::gpdsc_pin_drv_t [1:0] GENERAL_OUT_OUT,
    output gpdsc_pkg::gpdsc_pin_drv_t [6:0] GENERAL_IO_OUT,
    output logic [6:0] GENERAL_IO_STATUS_OUT,
    output logic SERIAL_TX_CLOCK_ENABLE_OUT,
    output logic SIGNAL_LOST_OUT
);
    import gpdsc_pkg::*;

    // the port widths are fixed at seven general pins and two outputs
    generate
        if (GPDSC_NUM_IO != 7) begin : g_chk_io
            $error("gpdsc_top serves exactly seven general pins");
        end
        if (GPDSC_NUM_OUT != 2) begin : g_chk_out
            $error("gpdsc_top serves exactly two general outputs");
        end
        if (GPDSC_SHARED_LO < 1 || GPDSC_SHARED_LO > GPDSC_NUM_IO) begin : g_chk_shared
            $error("gpdsc_top shared pin range out of bounds");
        end
    endgenerate

    // pin synchronisers: first stage read only by the second
    logic strap_s1_q, strap_s2_q;
    logic [6:0] io_s1_q, io_s2_q;
    logic optical_signal_loss_in_s1_q, optical_signal_loss_in_s2_q;
    always_ff @(posedge CLOCK_IN) begin
        strap_s1_q <= GENERAL_OUT_A_IN;
        strap_s2_q <= strap_s1_q;
        io_s1_q <= GENERAL_IO_IN;
        io_s2_q <= io_s1_q;
        optical_signal_loss_in_s1_q <= OPTICAL_SIGNAL_LOSS_IN;
        optical_signal_loss_in_s2_q <= optical_signal_loss_in_s1_q;
    end

    // strap captured while reset is held, frozen after release
    logic strap_q;
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            strap_q <= strap_s2_q; // R11
        end
    end

    // mode decode
    wire logic tbi_family = (MODE_IN == GPDSC_MODE_TBI) || (MODE_IN == GPDSC_MODE_RTBI);
    wire logic shared_ok = (MODE_IN == GPDSC_MODE_MII) || (MODE_IN == GPDSC_MODE_RGMII)
                           || (MODE_IN == GPDSC_MODE_RTBI); // R6

    // function selections, reset to GPDSC_FN_DEFAULT, except general pins 2 to 7, which reset to GPDSC_FN_HIZ
    gpdsc_fn_t out_fn_q [GPDSC_NUM_OUT];
    gpdsc_fn_t io_fn_q [GPDSC_NUM_IO];
    logic [1:0] out_lvl_q;
    logic [6:0] io_lvl_q;
    genvar g;
    generate
        for (g = 0; g < GPDSC_NUM_OUT; g++) begin : g_out
            always_ff @(posedge CLOCK_IN) begin
                if (!RST_N_IN) begin
                    out_fn_q[g] <= GPDSC_FN_DEFAULT; // R12
                    out_lvl_q[g] <= 1'b0;
                end else if (OUT_CFG_IN[g].write) begin
                    out_fn_q[g] <= OUT_CFG_IN[g].fn; // R7
                    out_lvl_q[g] <= OUT_CFG_IN[g].level;
                end
            end
            wire logic dflt = (g == 0) ? LINK_UP_IN : CARRIER_SENSE_IN; // R1 R2
            wire logic drive = (out_fn_q[g] == GPDSC_FN_DEFAULT) ? !tbi_family
                             : (out_fn_q[g] == GPDSC_FN_DRIVE);
            always_ff @(posedge CLOCK_IN) begin
                if (!RST_N_IN) begin
                    GENERAL_OUT_OUT[g] <= '0;
                end else begin
                    GENERAL_OUT_OUT[g].oe <= drive; // R1 R2 R11
                    GENERAL_OUT_OUT[g].data <= (out_fn_q[g] == GPDSC_FN_DEFAULT) ? dflt : out_lvl_q[g];
                end
            end
        end
        for (g = 0; g < GPDSC_NUM_IO; g++) begin : g_io
            always_ff @(posedge CLOCK_IN) begin
                if (!RST_N_IN) begin
                    io_fn_q[g] <= (g == 0) ? GPDSC_FN_DEFAULT : GPDSC_FN_HIZ; // R5 R12
                    io_lvl_q[g] <= 1'b0;
                end else if (IO_CFG_IN[g].write) begin
                    io_fn_q[g] <= IO_CFG_IN[g].fn; // R7
                    io_lvl_q[g] <= IO_CFG_IN[g].level;
                end
            end
            // shared pins only act as general pins in allowed modes
            wire logic usable = (g + 1 < GPDSC_SHARED_LO) || shared_ok; // R6
            wire logic drive = usable && ((io_fn_q[g] == GPDSC_FN_DRIVE)
                             || (io_fn_q[g] == GPDSC_FN_DEFAULT && g == 0 && strap_q)); // R3 R4 R13
            // the clock path is a pass-through so that 125MHz reaches the pin
            assign GENERAL_IO_OUT[g].oe = drive;
            assign GENERAL_IO_OUT[g].data = (io_fn_q[g] == GPDSC_FN_DEFAULT) ? (CLK125_IN && drive)
                                           : (io_lvl_q[g] && drive); // R4
            always_ff @(posedge CLOCK_IN) begin
                if (!RST_N_IN) begin
                    GENERAL_IO_STATUS_OUT[g] <= 1'b0;
                end else begin
                    GENERAL_IO_STATUS_OUT[g] <= io_s2_q[g]; // R13
                end
            end
        end
    endgenerate

    // serial transmit clock enable and loss-of-signal
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            SERIAL_TX_CLOCK_ENABLE_OUT <= GPDSC_TX_CLK_EN_RESET; // R8
            SIGNAL_LOST_OUT <= 1'b0;
        end else begin
            if (SERIAL_TX_CLOCK_ENABLE_WRITE_IN) begin
                SERIAL_TX_CLOCK_ENABLE_OUT <= SERIAL_TX_CLOCK_ENABLE_IN; // R8
            end
            SIGNAL_LOST_OUT <= optical_signal_loss_in_s2_q; // R9 R10
        end
    end

    // tx clock enable: off out of reset, follows each write
    a_txclk_off_reset: assert property ( // R8
        @(posedge CLOCK_IN) !RST_N_IN |=> !SERIAL_TX_CLOCK_ENABLE_OUT)
        else $error("tx clock enable set after reset");
    a_txclk_on_write: assert property ( // R8
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        SERIAL_TX_CLOCK_ENABLE_WRITE_IN |=> SERIAL_TX_CLOCK_ENABLE_OUT == $past(SERIAL_TX_CLOCK_ENABLE_IN))
        else $error("tx clock enable not written");

    // loss pin: three steady samples reach the status flag
    sequence s_los_pin_high;
        OPTICAL_SIGNAL_LOSS_IN ##1 OPTICAL_SIGNAL_LOSS_IN ##1 OPTICAL_SIGNAL_LOSS_IN;
    endsequence
    sequence s_los_pin_low;
        !OPTICAL_SIGNAL_LOSS_IN ##1 !OPTICAL_SIGNAL_LOSS_IN ##1 !OPTICAL_SIGNAL_LOSS_IN;
    endsequence
    a_los_follow: assert property ( // R9
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        $rose(optical_signal_loss_in_s2_q) |=> SIGNAL_LOST_OUT)
        else $error("loss of signal not reported");
    a_los_clear: assert property ( // R9
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        $fell(optical_signal_loss_in_s2_q) |=> !SIGNAL_LOST_OUT)
        else $error("loss of signal not cleared");
    a_los_chain_high: assert property ( // R9
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        s_los_pin_high |=> SIGNAL_LOST_OUT)
        else $error("held loss level not reported");
    a_los_chain_low: assert property ( // R10
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        s_los_pin_low |=> !SIGNAL_LOST_OUT)
        else $error("held normal level reported as loss");

    // reset defaults of the general pins
    a_io_hiz_reset: assert property ( // R5
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        $rose(RST_N_IN) |-> GENERAL_IO_OUT[1].oe == 1'b0 && GENERAL_IO_OUT[6].oe == 1'b0)
        else $error("general io not floating after reset");
    a_io1_strap: assert property ( // R3
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        $rose(RST_N_IN) |-> GENERAL_IO_OUT[0].oe == strap_q)
        else $error("io one does not follow strap");
    a_io1_clock: assert property ( // R4
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (io_fn_q[0] == GPDSC_FN_DEFAULT && strap_q) |-> GENERAL_IO_OUT[0].oe && GENERAL_IO_OUT[0].data == CLK125_IN)
        else $error("io one not passing the clock");
    a_strap_frozen: assert property ( // R11
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        $past(RST_N_IN) |-> $stable(strap_q))
        else $error("strap moved after reset");

    // default functions of the two outputs
    a_out_tbi_hiz: assert property ( // R1
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (out_fn_q[0] == GPDSC_FN_DEFAULT && tbi_family) |=> !GENERAL_OUT_OUT[0].oe)
        else $error("out a driven in tbi");
    a_out_link: assert property ( // R1
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (out_fn_q[0] == GPDSC_FN_DEFAULT && !tbi_family)
        |=> GENERAL_OUT_OUT[0].oe && GENERAL_OUT_OUT[0].data == $past(LINK_UP_IN))
        else $error("out a not link status");
    a_out_b_tbi_hiz: assert property ( // R2
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (out_fn_q[1] == GPDSC_FN_DEFAULT && tbi_family) |=> !GENERAL_OUT_OUT[1].oe)
        else $error("out b driven in tbi");
    a_out_carrier: assert property ( // R2
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (out_fn_q[1] == GPDSC_FN_DEFAULT && !tbi_family) |=> GENERAL_OUT_OUT[1].data == $past(CARRIER_SENSE_IN))
        else $error("out b not carrier sense");

    // software reassignment: write, register, then the pin
    sequence s_out_a_drive_write;
        OUT_CFG_IN[0].write && OUT_CFG_IN[0].fn == GPDSC_FN_DRIVE ##1 !OUT_CFG_IN[0].write;
    endsequence
    a_out_reassign: assert property ( // R7
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        s_out_a_drive_write |=> GENERAL_OUT_OUT[0].oe && GENERAL_OUT_OUT[0].data == $past(OUT_CFG_IN[0].level, 2))
        else $error("out a ignores reassignment");
    a_io_reassign: assert property ( // R7
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (IO_CFG_IN[1].write && IO_CFG_IN[1].fn == GPDSC_FN_DRIVE)
        |=> GENERAL_IO_OUT[1].oe && GENERAL_IO_OUT[1].data == $past(IO_CFG_IN[1].level))
        else $error("io two ignores reassignment");

    // shared pins and input pins
    a_shared_block: assert property ( // R6
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        !shared_ok |-> GENERAL_IO_OUT[3].oe == 1'b0 && GENERAL_IO_OUT[6].oe == 1'b0)
        else $error("shared pin driven in wrong mode");
    a_shared_usable: assert property ( // R6
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        (shared_ok && io_fn_q[3] == GPDSC_FN_DRIVE) |-> GENERAL_IO_OUT[3].oe && GENERAL_IO_OUT[3].data == io_lvl_q[3])
        else $error("shared pin not usable in allowed mode");
    a_input_off: assert property ( // R13
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        io_fn_q[4] == GPDSC_FN_INPUT |-> !GENERAL_IO_OUT[4].oe)
        else $error("input pin driving");
    a_status_follow: assert property ( // R13
        @(posedge CLOCK_IN) disable iff (!RST_N_IN)
        RST_N_IN |=> GENERAL_IO_STATUS_OUT[4] == $past(io_s2_q[4]))
        else $error("status bit not following pin");
endmodule : gpdsc_top
`default_nettype wire

//--- core/gpdsc_pkg.sv
// Contract
// (R1) after reset general_out_a floats in TBI or RTBI mode and otherwise drives link status, high meaning link up.
// (R2) after reset general_out_b floats in TBI or RTBI mode and otherwise drives carrier sense.
// (R3) if general_out_a was low during reset, general_io_1 floats after release.
// (R4) if general_out_a was high during reset, general_io_1 drives the 125MHz clock after release.
// (R5) general_io_2 to general_io_7 come out of reset floating.
// (R6) general_io_4 to general_io_7 serve as general pins only in MII, RGMII or RTBI mode.
// (R7) software may reassign every general pin after reset, and defaults hold only until it does.
// (R8) the 625MHz serial transmit clock is off after reset and on only when its enable bit is one.
// (R9) a low loss-of-signal input means normal operation and a high level means loss of signal.
// (R10) the board holds the loss-of-signal input low when the optical module has no such output.
// (R11) sampled-at-reset pins are captured during reset and then work as normal outputs.
// (R12) reset returns all state, including pin function selections, to defaults; the code leaves the pin synchroniser stages unreset.
// (R13) a general pin used as input keeps its driver off and shows the sampled level in a status bit.
package gpdsc_pkg;
    // parallel interface modes
    typedef enum logic [2:0] {
        GPDSC_MODE_GMII = 3'h0,
        GPDSC_MODE_RGMII = 3'h1,
        GPDSC_MODE_TBI = 3'h2,
        GPDSC_MODE_RTBI = 3'h3,
        GPDSC_MODE_MII = 3'h4
    } gpdsc_mode_t;
    // per-pin function codes
    typedef enum logic [1:0] {
        GPDSC_FN_HIZ = 2'h0,
        GPDSC_FN_DEFAULT = 2'h1,
        GPDSC_FN_DRIVE = 2'h2,
        GPDSC_FN_INPUT = 2'h3
    } gpdsc_fn_t;
    localparam int GPDSC_NUM_IO = 7;
    localparam int GPDSC_NUM_OUT = 2;
    localparam int GPDSC_SHARED_LO = 4;
    localparam int GPDSC_RESET_HOLD_CYCLES = 2;
    localparam logic GPDSC_TX_CLK_EN_RESET = 1'b0;
    localparam logic GPDSC_STRAP_RESET = 1'b0;
    // software control of one pin
    typedef struct packed {
        logic write;
        gpdsc_fn_t fn;
        logic level;
    } gpdsc_pin_cfg_t;
    // one driven pin: level and enable
    typedef struct packed {
        logic data;
        logic oe;
    } gpdsc_pin_drv_t;
endpackage : gpdsc_pkg

//--- verification/gpdsc_board_model.sv
`timescale 1ns/1ps
`default_nettype none
module gpdsc_board_model (
    input wire logic strap_hi_in,
    input wire logic los_hi_in,
    input wire logic [6:0] ext_in,
    input wire gpdsc_pkg::gpdsc_pin_drv_t [6:0] io_drv_in,
    output logic link_out,
    output logic carrier_out,
    output logic clk125_out,
    output logic los_out,
    output logic strap_out,
    output logic [6:0] pin_out
);
    import gpdsc_pkg::*;
    // 125MHz clock, offset so it never moves on a core edge
    initial begin
        clk125_out = 1'b0;
        #1;
        forever #4 clk125_out = ~clk125_out;
    end
    // link up, carrier idle: distinct levels expose swapped pins
    assign link_out = 1'b1;
    assign carrier_out = 1'b0;
    assign los_out = los_hi_in;
    assign strap_out = strap_hi_in;
    // pin level: device driver wins, else the board level
    always_comb begin
        for (int i = 0; i < 7; i++) pin_out[i] = io_drv_in[i].oe ? io_drv_in[i].data : ext_in[i];
    end
endmodule : gpdsc_board_model
`default_nettype wire

//--- verification/gpdsc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module gpdsc_top_tb;
    import gpdsc_pkg::*;
    logic clk, rst_n, strap, los, en, en_wr;
    logic [6:0] ext, stat;
    logic en_o, lost;
    gpdsc_mode_t mode;
    gpdsc_pin_cfg_t [1:0] ocfg;
    gpdsc_pin_cfg_t [6:0] icfg;
    gpdsc_pin_drv_t [1:0] gout;
    gpdsc_pin_drv_t [6:0] gio;
    wire logic link, crs, c125, los_p, strap_p;
    wire logic [6:0] pins;
    int n_fail = 0, comparisons = 0;
    gpdsc_board_model board (.strap_hi_in(strap), .los_hi_in(los), .ext_in(ext), .io_drv_in(gio),
        .link_out(link), .carrier_out(crs), .clk125_out(c125), .los_out(los_p), .strap_out(strap_p),
        .pin_out(pins));
    gpdsc_top dut (.CLOCK_IN(clk), .RST_N_IN(rst_n), .MODE_IN(mode), .LINK_UP_IN(link),
        .CARRIER_SENSE_IN(crs), .CLK125_IN(c125), .OPTICAL_SIGNAL_LOSS_IN(los_p),
        .SERIAL_TX_CLOCK_ENABLE_IN(en), .SERIAL_TX_CLOCK_ENABLE_WRITE_IN(en_wr), .OUT_CFG_IN(ocfg),
        .IO_CFG_IN(icfg), .GENERAL_OUT_A_IN(strap_p), .GENERAL_IO_IN(pins), .GENERAL_OUT_OUT(gout),
        .GENERAL_IO_OUT(gio), .GENERAL_IO_STATUS_OUT(stat), .SERIAL_TX_CLOCK_ENABLE_OUT(en_o),
        .SIGNAL_LOST_OUT(lost));
    task chk(input string n, input logic [1:0] e, input logic [1:0] s);
        comparisons++;
        if (s !== e) begin
            n_fail++;
            $display("wrong value %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task tick(input int k);
        repeat (k) @(negedge clk);
    endtask : tick
    task rst(input logic s);
        rst_n = 1'b0;
        strap = s;
        tick(16);
        rst_n = 1'b1;
        tick(3);
    endtask : rst
    task wr(input int i, input gpdsc_fn_t f, input logic v);
        icfg[i] = '{1'b1, f, v};
        tick(1);
        icfg[i].write = 1'b0;
    endtask : wr
    task t_defaults;
        chk("out_a", 2'h3, gout[0]);
        chk("out_b", 2'h1, gout[1]);
        chk("io1", {c125, 1'b1}, gio[0]);
        for (int i = 1; i < 7; i++) chk("io_oe", 2'h0, {1'b0, gio[i].oe});
        chk("txclk", 2'h0, {1'b0, en_o});
        for (int k = 2; k < 4; k++) begin
            mode = gpdsc_mode_t'(k);
            tick(2);
            chk("out_oe", 2'h0, {gout[0].oe, gout[1].oe});
        end
        mode = GPDSC_MODE_MII;
    endtask : t_defaults
    task t_reassign;
        wr(1, GPDSC_FN_DRIVE, 1'b1);
        chk("io2", 2'h3, gio[1]);
        wr(0, GPDSC_FN_HIZ, 1'b0);
        chk("io1", 2'h0, {1'b0, gio[0].oe});
        ocfg[0] = '{1'b1, GPDSC_FN_DRIVE, 1'b0};
        tick(1);
        ocfg[0].write = 1'b0;
        tick(1);
        chk("out_a", 2'h1, gout[0]);
        wr(3, GPDSC_FN_DRIVE, 1'b1);
        for (int m = 0; m < 5; m++) begin
            mode = gpdsc_mode_t'(m);
            tick(1);
            chk("io4", (m == 0 || m == 2) ? 2'h0 : 2'h3, gio[3]);
        end
        wr(4, GPDSC_FN_INPUT, 1'b1);
        ext[4] = 1'b1;
        tick(3);
        chk("io5", 2'h1, {gio[4].oe, stat[4]});
        ext[4] = 1'b0;
        tick(3);
        chk("io5", 2'h0, {gio[4].oe, stat[4]});
    endtask : t_reassign
    task t_serial;
        en = 1'b1;
        tick(1);
        chk("txclk", 2'h0, {1'b0, en_o});
        en_wr = 1'b1;
        tick(1);
        en_wr = 1'b0;
        chk("txclk", 2'h1, {1'b0, en_o});
        los = 1'b1;
        tick(4);
        chk("lost", 2'h1, {1'b0, lost});
        los = 1'b0;
        tick(4);
        chk("lost", 2'h0, {1'b0, lost});
    endtask : t_serial
    task t_rereset;
        rst(1'b0);
        chk("io1_io2", 2'h0, {gio[0].oe, gio[1].oe});
        chk("txclk_out_a", 2'h3, {~en_o, gout[0].data});
    endtask : t_rereset
    task tally_and_finish;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // cut a hang short
    initial begin
        #100000;
        n_fail++;
        tally_and_finish();
    end
    initial begin
        {rst_n, strap, los, en, en_wr, ext, ocfg, icfg} = '0;
        mode = GPDSC_MODE_GMII;
        rst(1'b1);
        t_defaults();
        t_reassign();
        t_serial();
        t_rereset();
        tally_and_finish();
    end
endmodule : gpdsc_top_tb
`default_nettype wire
